// file: hw/gpb_port.v
// one sixteen-pin general-purpose port module
`timescale 1ns/1ns
`default_nettype none
`include "gpb_regs.vh"
module gpb_port #(
   parameter W = `GPB_PORT_WIDTH,
   parameter FORCE_GPIO = 0
) (
   input wire clk,
   input wire rst,
   input wire [2:0] out_op,
   input wire [W-1:0] out_data,
   input wire dir_we,
   input wire [W-1:0] dir_data,
   input wire inen_we,
   input wire [W-1:0] inen_data,
   input wire mux_we,
   input wire [W-1:0] mux_data,
   input wire [W-1:0] mask_set,
   input wire [W-1:0] mask_clr,
   input wire sense_we,
   input wire [W-1:0] sense_data,
   input wire edge_we,
   input wire [W-1:0] edge_data,
   input wire [W-1:0] irq_clr,
   input wire [W-1:0] pin_in,
   input wire [W-1:0] periph_out,
   input wire [W-1:0] periph_oe,
   output reg [W-1:0] pin_out,
   output reg [W-1:0] pin_oe,
   output reg [W-1:0] periph_in,
   output reg [W-1:0] status_r,
   output reg [W-1:0] dir_r,
   output reg [W-1:0] mask_r,
   output reg [W-1:0] pend_r,
   output reg irq_r
);
   reg [W-1:0] outv_r, outv_nxt, inen_r, mux_r, sense_r, edge_r;
   reg [W-1:0] meta_r, sync_r, prev_r, pend_nxt, req;
   reg [W-1:0] gmask;
   integer i;

   // general-purpose ownership; variant without network controller pins it to gpio
   always @* begin
      gmask = FORCE_GPIO ? {W{1'b1}} : mux_r;
   end

   // output value: set, clear and toggle change ones and hold zeros; value op loads every bit
   always @* begin
      outv_nxt = outv_r;
      case (out_op)
         `GPB_OP_SET: outv_nxt = outv_r | out_data;
         `GPB_OP_CLR: outv_nxt = outv_r & ~out_data;
         `GPB_OP_TGL: outv_nxt = outv_r ^ out_data;
         `GPB_OP_VAL: outv_nxt = out_data;
         default: outv_nxt = outv_r;
      endcase
   end

   // control registers; all zero out of reset except the mux, which selects gpio
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         outv_r <= `GPB_RST_ZERO;
         dir_r <= `GPB_RST_ZERO;
         inen_r <= `GPB_RST_ZERO;
         mux_r <= `GPB_RST_MUX_GPIO;
         mask_r <= `GPB_RST_ZERO;
         sense_r <= `GPB_RST_ZERO;
         edge_r <= `GPB_RST_ZERO;
      end else begin
         outv_r <= outv_nxt;
         if (dir_we) dir_r <= dir_data;
         if (inen_we) inen_r <= inen_data;
         if (mux_we) mux_r <= mux_data;
         mask_r <= (mask_r | mask_set) & ~mask_clr;
         if (sense_we) sense_r <= sense_data;
         if (edge_we) edge_r <= edge_data;
      end
   end

   // request per pin: inputs by sensitivity, outputs on software change
   // edges count only while the input buffer is on, so opening it is no edge
   always @* begin
      for (i = 0; i < W; i = i + 1) begin
         if (dir_r[i])
            req[i] = outv_nxt[i] != outv_r[i];
         else if (sense_r[i] == `GPB_SENSE_LEVEL)
            req[i] = 1'b0;
         else if (edge_r[i] == `GPB_EDGE_RISE)
            req[i] = inen_r[i] & sync_r[i] & ~prev_r[i];
         else
            req[i] = inen_r[i] & (sync_r[i] ^ prev_r[i]);
      end
      // set wins over clear for latched edges
      pend_nxt = ((pend_r & ~irq_clr) | req) & gmask;
      for (i = 0; i < W; i = i + 1) begin
         if (!dir_r[i] && sense_r[i] == `GPB_SENSE_LEVEL)
            pend_nxt[i] = sync_r[i] & inen_r[i] & gmask[i];
      end
   end

   // pin sync, status, pending and pad drive
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= `GPB_RST_ZERO;
         sync_r <= `GPB_RST_ZERO;
         prev_r <= `GPB_RST_ZERO;
         status_r <= `GPB_RST_ZERO;
         pend_r <= `GPB_RST_ZERO;
         irq_r <= 1'b0;
         pin_out <= `GPB_RST_ZERO;
         pin_oe <= `GPB_RST_ZERO;
         periph_in <= `GPB_RST_ZERO;
      end else begin
         // sync runs freely so the edge history is settled before the buffer opens
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
         // buffer gating: an unconfigured gpio pin reads low
         status_r <= sync_r & (inen_r | dir_r) & gmask;
         pend_r <= pend_nxt;
         irq_r <= |(pend_nxt & mask_r);
         pin_out <= (outv_nxt & gmask) | (periph_out & ~gmask);
         pin_oe <= (dir_r & gmask) | (periph_oe & ~gmask);
         periph_in <= sync_r & ~gmask;
      end
   end
endmodule // gpb_port
`default_nettype wire

// file: hw/gpb_regs.vh
// constants for the general-purpose port bank
// What this block does
// - forty-eight bidirectional pins in three independent sixteen-pin port modules
// - each pin muxed with a peripheral; general-purpose function selected after power-up
// - after reset no output driver or input buffer is enabled
// - per-pin direction bit picks input or driven output
// - modify writes change only pins written with one
// - set register one drives pin output high
// - clear register one drives pin output low
// - toggle register one inverts pin output
// - fourth register writes the output level directly
// - status read returns sensed level of each pin; reads low unless gpio-owned with input buffer or driver on
// - mask set register ones enable interrupts, others unchanged
// - mask clear register ones disable interrupts, others unchanged
// - enabled input pin raises request on its sensitivity condition
// - enabled output pin raises interrupt when software changes its value
// - per-pin sensitivity bit chooses level or edge
// - per-pin edge bit chooses rising only or both edges
// - fourth lettered port has peripheral functions only, no general-purpose pins
// - variant without network controller: third port pins are general-purpose only
`ifndef GPB_REGS_VH
`define GPB_REGS_VH
`define GPB_PORT_WIDTH 16
`define GPB_NUM_PORTS 3
`define GPB_RST_ZERO 16'h0000
`define GPB_RST_MUX_GPIO 16'hffff
`define GPB_SENSE_LEVEL 1'b0
`define GPB_EDGE_RISE 1'b0
`define GPB_OP_NONE 3'h0
`define GPB_OP_SET 3'h1
`define GPB_OP_CLR 3'h2
`define GPB_OP_TGL 3'h3
`define GPB_OP_VAL 3'h4
`endif

// file: hw/gpb_bank.v
// three-port general-purpose pin bank top
`timescale 1ns/1ns
`default_nettype none
`include "gpb_regs.vh"
module gpb_bank #(
   parameter W = `GPB_PORT_WIDTH,
   parameter NO_NET_CTRL = 0
) (
   input wire clk,
   input wire rst,
   input wire [1:0] port_sel,
   input wire [2:0] out_op,
   input wire [W-1:0] out_data,
   input wire dir_we,
   input wire [W-1:0] dir_data,
   input wire inen_we,
   input wire [W-1:0] inen_data,
   input wire mux_we,
   input wire [W-1:0] mux_data,
   input wire [W-1:0] mask_set,
   input wire [W-1:0] mask_clr,
   input wire sense_we,
   input wire [W-1:0] sense_data,
   input wire edge_we,
   input wire [W-1:0] edge_data,
   input wire [W-1:0] irq_clr,
   input wire [3*W-1:0] pin_in,
   input wire [3*W-1:0] periph_out,
   input wire [3*W-1:0] periph_oe,
   output wire [3*W-1:0] pin_out,
   output wire [3*W-1:0] pin_oe,
   output wire [3*W-1:0] periph_in,
   output wire [3*W-1:0] pin_status,
   output wire [3*W-1:0] dir_state,
   output wire [3*W-1:0] mask_state,
   output wire [3*W-1:0] irq_pending,
   output wire [2:0] irq
);
   // decode of the selected port, used by every strobe
   function sel_hit;
      input [1:0] sel;
      input [1:0] idx;
      begin
         sel_hit = sel == idx;
      end
   endfunction

   // three independent modules; the fourth select value reaches no gpio
   genvar p;
   generate
      for (p = 0; p < `GPB_NUM_PORTS; p = p + 1) begin : g_port
         localparam integer PI = p;
         wire hit;
         assign hit = sel_hit(port_sel, PI[1:0]);
         gpb_port #(.W(W), .FORCE_GPIO((p == 2) && NO_NET_CTRL)) u_port (
            .clk(clk),
            .rst(rst),
            .out_op(hit ? out_op : `GPB_OP_NONE),
            .out_data(out_data),
            .dir_we(hit & dir_we),
            .dir_data(dir_data),
            .inen_we(hit & inen_we),
            .inen_data(inen_data),
            .mux_we(hit & mux_we),
            .mux_data(mux_data),
            .mask_set(hit ? mask_set : `GPB_RST_ZERO),
            .mask_clr(hit ? mask_clr : `GPB_RST_ZERO),
            .sense_we(hit & sense_we),
            .sense_data(sense_data),
            .edge_we(hit & edge_we),
            .edge_data(edge_data),
            .irq_clr(hit ? irq_clr : `GPB_RST_ZERO),
            .pin_in(pin_in[p*W +: W]),
            .periph_out(periph_out[p*W +: W]),
            .periph_oe(periph_oe[p*W +: W]),
            .pin_out(pin_out[p*W +: W]),
            .pin_oe(pin_oe[p*W +: W]),
            .periph_in(periph_in[p*W +: W]),
            .status_r(pin_status[p*W +: W]),
            .dir_r(dir_state[p*W +: W]),
            .mask_r(mask_state[p*W +: W]),
            .pend_r(irq_pending[p*W +: W]),
            .irq_r(irq[p])
         );
      end
   endgenerate
endmodule // gpb_bank
`default_nettype wire

// file: test/gpb_bank_asserts.sv
// concurrent checks on the port bank top
`timescale 1ns/1ns
`default_nettype none
module gpb_bank_asserts #(parameter W = 16) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] port_sel,
   input wire logic [2:0] out_op,
   input wire logic [W-1:0] out_data,
   input wire logic dir_we,
   input wire logic [W-1:0] dir_data,
   input wire logic [W-1:0] mask_set,
   input wire logic [W-1:0] mask_clr,
   input wire logic [3*W-1:0] pin_out,
   input wire logic [3*W-1:0] pin_oe,
   input wire logic [3*W-1:0] dir_state,
   input wire logic [3*W-1:0] mask_state,
   input wire logic [2:0] irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // an input pin must stay undriven once its direction has settled
   sequence inp_held;
      !dir_state[0] [*2];
   endsequence
   sequence set_req;
      out_op == 3'h1 && port_sel == 2'h0 && out_data[0] && dir_state[0];
   endsequence
   sequence clr_req;
      out_op == 3'h2 && port_sel == 2'h0 && out_data[0] && dir_state[0];
   endsequence
   quiet_reset_a: assert property ($fell(rst) |-> pin_oe == 0 && irq == 0)
      else $error("outputs active after reset");
   input_off_a: assert property (inp_held |-> !pin_oe[0])
      else $error("input pin driven");
   dir_load_a: assert property (dir_we && port_sel == 2'h0 |=> dir_state[W-1:0] == $past(dir_data))
      else $error("direction not loaded");
   set_high_a: assert property (set_req |-> ##[1:2] pin_out[0])
      else $error("set did not drive high");
   clr_low_a: assert property (clr_req |-> ##[1:2] !pin_out[0])
      else $error("clear did not drive low");
   mask_on_a: assert property (port_sel == 2'h1 && mask_set[4] && !mask_clr[4] |=> mask_state[20])
      else $error("mask set lost");
   mask_off_a: assert property (port_sel == 2'h1 && mask_clr[4] |=> !mask_state[20])
      else $error("mask clear lost");
   fourth_port_a: assert property (port_sel == 2'h3 |=> $stable(mask_state) && $stable(dir_state))
      else $error("fourth port changed state");
   irq_quiet_a: assert property ((mask_state[W-1:0] == 0) [*2] |-> !irq[0])
      else $error("irq with mask off");
endmodule // gpb_bank_asserts
bind gpb_bank gpb_bank_asserts #(.W(W)) u_chk (.clk(clk), .rst(rst), .port_sel(port_sel),
   .out_op(out_op), .out_data(out_data), .dir_we(dir_we), .dir_data(dir_data),
   .mask_set(mask_set), .mask_clr(mask_clr), .pin_out(pin_out), .pin_oe(pin_oe),
   .dir_state(dir_state), .mask_state(mask_state), .irq(irq));
`default_nettype wire

// file: test/gpb_pin_model.sv
// external devices wired to the port pins
`timescale 1ns/1ns
`default_nettype none
module gpb_pin_model (
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] ext_lvl,
   output logic [47:0] pin_in
);
   // a driven pin reads back its own level, an undriven one the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpb_pin_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the port bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst, dir_we, inen_we, sense_we, edge_we, mux_we;
   logic [1:0] port_sel;
   logic [2:0] out_op, irq;
   logic [15:0] dat, mask_set, mask_clr, irq_clr;
   logic [47:0] pin_in, pin_out, pin_oe, ext_lvl, pin_status, dir_state, mask_state, irq_pending;
   logic [47:0] periph_out, periph_oe, periph_in, pin_out_b, periph_in_b;
   int error_cnt, num_checks;
   gpb_bank u_dut (.clk(clk), .rst(rst), .port_sel(port_sel), .out_op(out_op), .out_data(dat),
      .dir_we(dir_we), .dir_data(dat), .inen_we(inen_we), .inen_data(dat), .mux_we(mux_we),
      .mux_data(dat), .mask_set(mask_set), .mask_clr(mask_clr), .sense_we(sense_we),
      .sense_data(dat), .edge_we(edge_we), .edge_data(dat), .irq_clr(irq_clr), .pin_in(pin_in),
      .periph_out(periph_out), .periph_oe(periph_oe), .pin_out(pin_out),
      .pin_oe(pin_oe), .periph_in(periph_in), .pin_status(pin_status), .dir_state(dir_state),
      .mask_state(mask_state), .irq_pending(irq_pending), .irq(irq));
   // second bank built for the variant without the network controller
   gpb_bank #(.NO_NET_CTRL(1)) u_dut_gp (.clk(clk), .rst(rst), .port_sel(port_sel),
      .out_op(out_op), .out_data(dat), .dir_we(dir_we), .dir_data(dat), .inen_we(inen_we),
      .inen_data(dat), .mux_we(mux_we), .mux_data(dat), .mask_set(mask_set),
      .mask_clr(mask_clr), .sense_we(sense_we), .sense_data(dat), .edge_we(edge_we),
      .edge_data(dat), .irq_clr(irq_clr), .pin_in(pin_in), .periph_out(periph_out),
      .periph_oe(periph_oe), .pin_out(pin_out_b), .pin_oe(), .periph_in(periph_in_b),
      .pin_status(), .dir_state(), .mask_state(), .irq_pending(), .irq());
   gpb_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
   task close_out;
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // one strobe: 1-4 output ops, 5 dir, 6 inen, 7/8 mask, 9 sense, 10 edge, 11 clear, 12 mux
   task pulse(input logic [1:0] s, input logic [3:0] k, input logic [15:0] d);
      @(posedge clk);
      port_sel <= s;
      dat <= d;
      out_op <= (k < 4'd5) ? k[2:0] : 3'h0;
      {dir_we, inen_we, sense_we, edge_we} <= {k == 4'd5, k == 4'd6, k == 4'd9, k == 4'd10};
      mux_we <= k == 4'd12;
      mask_set <= (k == 4'd7) ? d : 16'h0000;
      mask_clr <= (k == 4'd8) ? d : 16'h0000;
      irq_clr <= (k == 4'd11) ? d : 16'h0000;
      @(posedge clk);
      {out_op, dir_we, inen_we, sense_we, edge_we, mux_we, mask_set, mask_clr, irq_clr} <= 0;
      // pin paths need up to four edges; look on the falling edge, away from any launch
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   task ext(input int i, input logic v);
      @(posedge clk);
      ext_lvl[i] <= v;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      close_out;
   end
   initial begin
      rst = 1;
      {port_sel, out_op, dir_we, inen_we, sense_we, edge_we, mux_we} = 0;
      periph_out = 48'habcd_0000_0000;
      periph_oe = 48'h0f00_0000_0000;
      {dat, mask_set, mask_clr, irq_clr} = 0;
      ext_lvl = 48'hffff_a5a5_ffff;
      error_cnt = 0;
      num_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(pin_oe, 0);
      chk(pin_status, 0);
      pulse(0, 5, 16'hffff);
      chk(pin_oe[15:0], 16'hffff);
      pulse(0, 1, 16'h00f1);
      chk(pin_out[15:0], 16'h00f1);
      pulse(0, 2, 16'h0031);
      chk(pin_out[15:0], 16'h00c0);
      pulse(0, 3, 16'h0f0f);
      chk(pin_out[15:0], 16'h0fcf);
      pulse(0, 4, 16'h1234);
      chk(pin_out[15:0], 16'h1234);
      pulse(3, 4, 16'hffff);
      chk(pin_out[15:0], 16'h1234);
      pulse(1, 9, 16'hffff);
      pulse(1, 6, 16'hffff);
      chk(pin_status[31:16], 16'ha5a5);
      pulse(1, 11, 16'hffff);
      pulse(1, 7, 16'h00ff);
      pulse(1, 7, 16'h0f00);
      chk(mask_state[31:16], 16'h0fff);
      pulse(1, 8, 16'h0011);
      chk(mask_state[31:16], 16'h0fee);
      ext(17, 1);
      chk({irq[1], irq_pending[17]}, 2'b11);
      ext(17, 0);
      chk({irq[1], irq_pending[17]}, 2'b11);
      pulse(1, 11, 16'h0002);
      chk({irq[1], irq_pending[17]}, 2'b00);
      pulse(1, 10, 16'hffff);
      ext(17, 1);
      pulse(1, 11, 16'h0002);
      ext(17, 0);
      chk(irq_pending[17], 1'b1);
      pulse(1, 9, 16'h0000);
      chk(irq_pending[18], 1'b1);
      ext(18, 0);
      chk(irq_pending[18], 1'b0);
      pulse(0, 11, 16'hffff);
      pulse(0, 7, 16'h0001);
      pulse(0, 3, 16'h0001);
      chk({irq[0], irq_pending[0]}, 2'b11);
      pulse(2, 5, 16'hffff);
      pulse(2, 4, 16'h5a5a);
      chk(pin_out[47:32], 16'h5a5a);
      pulse(2, 12, 16'h00ff);
      chk(pin_out[47:32], 16'hab5a);
      chk(pin_oe[47:32], 16'h0fff);
      chk(periph_in[47:32], 16'hfb00);
      chk(pin_out_b[47:32], 16'h5a5a);
      chk(periph_in_b[47:32], 16'h0000);
      close_out;
   end
endmodule // testbench
`default_nettype wire
